// [scs_cmd_interp.sv]
/*
 Common and system command interpreter. Takes pre-parsed commands with up to
 three numeric arguments, executes them and hands replies out one at a time.
 Assumes an upstream parser supplies opcodes and a downstream formatter turns
 reply kinds and data into text; all inputs are on the system clock.
 */
`timescale 1ns/10ps
`include "scs_defines.svh"
module scs_cmd_interp #(
  parameter int SEC_CYCLES = `SCS_SEC_CYCLES,
  parameter logic [31:0] MFR_ID = 32'h0000_00A1,   // Arbitrary value
  parameter logic [31:0] MODEL_ID = 32'h0000_00B2, // Arbitrary value
  parameter logic [31:0] SERIAL_NO = 32'h0000_0001,
  parameter logic [23:0] FW_REV = 24'h01_00_00,
  parameter int ERRQ_DEPTH = 8
) (
  input wire logic i_clk_sys,               // System clock
  input wire logic i_reset_n,               // Async reset, active low
  input wire logic i_cmd_valid,             // Command offered
  output logic o_cmd_ready,                 // Command taken when valid too
  input wire logic [4:0] i_cmd_op,          // Command opcode
  input wire logic [15:0] i_cmd_arg0,       // First argument
  input wire logic [15:0] i_cmd_arg1,       // Second argument
  input wire logic [15:0] i_cmd_arg2,       // Third argument
  input wire logic i_cmd_end,               // Last command before terminator
  output logic o_resp_valid,                // Reply waiting
  input wire logic i_resp_ready,            // Reply consumed
  output logic [3:0] o_resp_kind,           // Reply format
  output logic [31:0] o_resp_data,          // Reply value
  input wire logic i_meas_active,           // Trigger layers running
  output logic o_selftest_start,            // Start self-test pulse
  input wire logic i_selftest_done,         // Self-test finished pulse
  input wire logic [7:0] i_selftest_code,   // Self-test result
  output logic o_inst_reset,                // Instrument default pulse
  output logic o_beep,                      // Beeper pulse
  output logic o_beeper_en,                 // Beeper enabled
  output logic o_line_freq_60,              // Mains 60 Hz, else 50 Hz
  output logic o_path_root,                 // Command path at root
  output logic [7:0] o_status_byte          // Status byte
);
  function automatic logic op_hit(input logic [4:0] op, input logic [4:0] code);
    return op == code;
  endfunction

  scs_pkg::scs_state_t st_q;
  scs_pkg::scs_state_t st_d;
  logic [7:0] esr_q, ese_q, sre_q;
  logic opc_pend_q, opcq_pend_q;
  logic tst_have_q;
  logic [7:0] tst_code_q;
  logic [1:0] idn_idx_q;
  logic resp_valid_q;
  logic [3:0] resp_kind_q;
  logic [31:0] resp_data_q;
  logic beep_q, beep_en_q, lfr60_q, root_q, rst_q, tst_start_q;
  logic [7:0] stb_q;
  logic [15:0] year_q;
  logic [7:0] month_q, day_q, hour_q, min_q, sec_q;
  logic [23:0] div_q;
  logic put_en;
  logic [3:0] put_kind;
  logic [31:0] put_data;
  logic [15:0] err_head;
  logic err_empty;

  wire logic idle_st = st_q == scs_pkg::ST_IDLE;
  wire logic slot_free = ~resp_valid_q | i_resp_ready;
  // Completion waits for the trigger layers and any running self-test
  wire logic flush_opc = opc_pend_q & ~i_meas_active & idle_st;                // [R7] [R10]
  wire logic flush_opcq = opcq_pend_q & ~i_meas_active & idle_st & slot_free; // [R8] [R10]
  // Only reset and completion requests pass while measuring; the rest stall
  wire logic busy_ok = op_hit(i_cmd_op, `SCS_OP_RST) | op_hit(i_cmd_op, `SCS_OP_OPC)
                       | op_hit(i_cmd_op, `SCS_OP_OPCQ);
  assign o_cmd_ready = idle_st & slot_free & ~flush_opcq & (~i_meas_active | busy_ok); // [R9]
  wire logic take = i_cmd_valid & o_cmd_ready;

  wire logic d_cls = take & op_hit(i_cmd_op, `SCS_OP_CLS);
  wire logic d_ese = take & op_hit(i_cmd_op, `SCS_OP_ESE);
  wire logic d_esrq = take & op_hit(i_cmd_op, `SCS_OP_ESRQ);
  wire logic d_idnq = take & op_hit(i_cmd_op, `SCS_OP_IDNQ);
  wire logic d_opc = take & op_hit(i_cmd_op, `SCS_OP_OPC);
  wire logic d_opcq = take & op_hit(i_cmd_op, `SCS_OP_OPCQ);
  wire logic d_rst = take & op_hit(i_cmd_op, `SCS_OP_RST);
  wire logic d_sre = take & op_hit(i_cmd_op, `SCS_OP_SRE);
  wire logic d_tstq = take & op_hit(i_cmd_op, `SCS_OP_TSTQ);
  wire logic d_beep = take & op_hit(i_cmd_op, `SCS_OP_BEEP);
  wire logic d_beepst = take & op_hit(i_cmd_op, `SCS_OP_BEEPST);
  wire logic d_errq = take & op_hit(i_cmd_op, `SCS_OP_ERRQ);
  wire logic d_date = take & op_hit(i_cmd_op, `SCS_OP_DATE);
  wire logic d_time = take & op_hit(i_cmd_op, `SCS_OP_TIME);
  wire logic d_lfr = take & op_hit(i_cmd_op, `SCS_OP_LFR);
  wire logic d_bad = take & (i_cmd_op > `SCS_OP_LFRQ);

  // Argument checks
  wire logic lfr_ok = i_cmd_arg0 == `SCS_LFR_50 || i_cmd_arg0 == `SCS_LFR_60;
  wire logic date_ok = i_cmd_arg1[7:0] != 8'h00 && i_cmd_arg1 <= {8'h00, `SCS_MONTH_MAX}
                       && i_cmd_arg2[7:0] != 8'h00 && i_cmd_arg2 <= {8'h00, `SCS_DAY_MAX};
  wire logic time_ok = i_cmd_arg0 <= {8'h00, `SCS_HOUR_MAX}
                       && i_cmd_arg1 <= {8'h00, `SCS_SEC_MAX}
                       && i_cmd_arg2 <= {8'h00, `SCS_SEC_MAX};
  wire logic arg_err = (d_lfr & ~lfr_ok) | (d_date & ~date_ok) | (d_time & ~time_ok); // [R21]
  wire logic err_push = arg_err | d_bad;
  wire logic [15:0] err_code = d_bad ? `SCS_ERR_HEADER : `SCS_ERR_RANGE;

  // Standard event register: hardware sets win over read or clear
  logic [7:0] esr_set;
  always_comb begin
    esr_set = 8'h00;
    esr_set[`SCS_ESR_OPC] = flush_opc;
    esr_set[`SCS_ESR_EXE] = arg_err;
    esr_set[`SCS_ESR_CME] = d_bad;
  end
  wire logic esr_clr = d_cls | d_esrq;                          // [R1] [R3]
  wire logic [7:0] esr_d = (esr_q & ~{8{esr_clr}}) | esr_set;

  // Status byte summary bits
  logic [7:0] stb_low;
  always_comb begin
    stb_low = 8'h00;
    stb_low[`SCS_STB_EAV] = ~err_empty;
    stb_low[`SCS_STB_MAV] = resp_valid_q;
    stb_low[`SCS_STB_ESB] = |(esr_q & ese_q);
  end
  wire logic mss = |(stb_low & sre_q);
  wire logic [7:0] stb = stb_low | (8'h01 << `SCS_STB_MSS) & {8{mss}};

  // One-second enable for the time-of-day clock
  wire logic sec_tick = div_q == 24'(SEC_CYCLES - 1);

  // Reply source selection, one reply per cycle
  always_comb begin
    put_en = 1'b0;
    put_kind = `SCS_RK_NUM;
    put_data = 32'h0000_0000;
    if (flush_opcq) begin
      put_en = 1'b1;
      put_kind = `SCS_RK_CHAR;
      put_data = `SCS_ASCII_ONE;                                // [R8]
    end else if (st_q == scs_pkg::ST_TEST && tst_have_q && slot_free) begin
      put_en = 1'b1;
      put_data = {24'h00_0000, tst_code_q};                     // [R12]
    end else if (st_q == scs_pkg::ST_IDN && slot_free) begin
      put_en = 1'b1;
      put_kind = `SCS_RK_IDN0 + {2'b00, idn_idx_q};             // [R6]
      case (idn_idx_q)
        2'd0: put_data = MFR_ID;
        2'd1: put_data = MODEL_ID;
        2'd2: put_data = SERIAL_NO;
        default: put_data = {8'h00, FW_REV};
      endcase
    end else if (take) begin
      put_en = 1'b1;
      case (i_cmd_op)
        `SCS_OP_ESEQ: put_data = {24'h00_0000, ese_q};         // [R2]
        `SCS_OP_ESRQ: put_data = {24'h00_0000, esr_q};         // [R3]
        `SCS_OP_SREQ: put_data = {24'h00_0000, sre_q};         // [R4]
        `SCS_OP_STBQ: put_data = {24'h00_0000, stb};           // [R5]
        `SCS_OP_BEEPSTQ: begin
          put_kind = `SCS_RK_BOOL;
          put_data = {31'h0000_0000, beep_en_q};                // [R14]
        end
        `SCS_OP_ERRQ: begin
          put_kind = `SCS_RK_ERR;
          put_data = {16'h0000, err_empty ? 16'h0000 : err_head}; // [R15]
        end
        `SCS_OP_VERSQ: begin
          put_kind = `SCS_RK_VERS;
          put_data = `SCS_VERSION;                              // [R16]
        end
        `SCS_OP_DATEQ: begin
          put_kind = `SCS_RK_DATE;
          put_data = {year_q, month_q, day_q};                  // [R17]
        end
        `SCS_OP_TIMEQ: begin
          put_kind = `SCS_RK_TIME;
          put_data = {8'h00, hour_q, min_q, sec_q};             // [R18]
        end
        `SCS_OP_LFRQ: put_data = {16'h0000, lfr60_q ? `SCS_LFR_60 : `SCS_LFR_50}; // [R19]
        default: put_en = 1'b0;
      endcase
    end
  end

  // Sequencer for multi-step replies
  always_comb begin
    st_d = st_q;
    case (st_q)
      scs_pkg::ST_IDLE: begin
        if (d_tstq) begin
          st_d = scs_pkg::ST_TEST;
        end else if (d_idnq) begin
          st_d = scs_pkg::ST_IDN;
        end
      end
      scs_pkg::ST_TEST: begin
        if (tst_have_q && slot_free) begin
          st_d = scs_pkg::ST_IDLE;
        end
      end
      scs_pkg::ST_IDN: begin
        if (slot_free && idn_idx_q == 2'd3) begin
          st_d = scs_pkg::ST_IDLE;
        end
      end
      default: st_d = scs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= scs_pkg::ST_IDLE;
      idn_idx_q <= 2'd0;
      tst_have_q <= 1'b0;
      tst_code_q <= 8'h00;
    end else begin
      st_q <= st_d;
      if (st_q == scs_pkg::ST_IDN && slot_free) begin
        idn_idx_q <= idn_idx_q + 2'd1;
      end
      if (d_tstq) begin
        tst_have_q <= 1'b0;
      end else if (st_q == scs_pkg::ST_TEST && i_selftest_done) begin
        tst_have_q <= 1'b1;
        tst_code_q <= i_selftest_code;
      end
    end
  end

  // Status and completion state
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      esr_q <= 8'h00;
      ese_q <= 8'h00;
      sre_q <= 8'h00;
      opc_pend_q <= 1'b0;
      opcq_pend_q <= 1'b0;
      stb_q <= 8'h00;
    end else begin
      esr_q <= esr_d;
      stb_q <= stb;
      if (d_ese) begin
        ese_q <= i_cmd_arg0[7:0];                               // [R2]
      end
      if (d_sre) begin
        sre_q <= i_cmd_arg0[7:0];                               // [R4]
      end
      // Reset drops any completion still owed
      if (d_rst) begin
        opc_pend_q <= 1'b0;                                     // [R11]
        opcq_pend_q <= 1'b0;
      end else begin
        opc_pend_q <= d_opc | (opc_pend_q & ~flush_opc);        // [R7]
        opcq_pend_q <= d_opcq | (opcq_pend_q & ~flush_opcq);    // [R8]
      end
    end
  end

  // Reply register, held until consumed
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      resp_valid_q <= 1'b0;
      resp_kind_q <= `SCS_RK_NUM;
      resp_data_q <= 32'h0000_0000;
    end else if (put_en) begin
      resp_valid_q <= 1'b1;
      resp_kind_q <= put_kind;
      resp_data_q <= put_data;
    end else if (i_resp_ready) begin
      resp_valid_q <= 1'b0;
    end
  end

  // Settings and pulses; the wait command falls through untouched [R13]
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      beep_q <= 1'b0;
      beep_en_q <= `SCS_BEEP_EN_RST;
      lfr60_q <= `SCS_LFR60_RST;
      root_q <= 1'b1;
      rst_q <= 1'b0;
      tst_start_q <= 1'b0;
    end else begin
      beep_q <= d_beep & beep_en_q;                             // [R14]
      rst_q <= d_rst;                                           // [R11]
      tst_start_q <= d_tstq;                                    // [R12]
      if (take) begin
        root_q <= i_cmd_end;                                    // [R20]
      end
      if (d_rst) begin
        beep_en_q <= `SCS_BEEP_EN_RST;
        lfr60_q <= `SCS_LFR60_RST;
      end else begin
        if (d_beepst) begin
          beep_en_q <= i_cmd_arg0 != 16'h0000;                  // [R14]
        end
        if (d_lfr && lfr_ok) begin
          lfr60_q <= i_cmd_arg0 == `SCS_LFR_60;                 // [R19] [R21]
        end
      end
    end
  end

  // Calendar and running time of day; midnight does not advance the date
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      year_q <= 16'h0000;
      month_q <= 8'h01;
      day_q <= 8'h01;
      hour_q <= 8'h00;
      min_q <= 8'h00;
      sec_q <= 8'h00;
      div_q <= 24'h00_0000;
    end else begin
      if (d_date && date_ok) begin
        year_q <= i_cmd_arg0;                                   // [R17]
        month_q <= i_cmd_arg1[7:0];
        day_q <= i_cmd_arg2[7:0];
      end
      if (d_time && time_ok) begin
        hour_q <= i_cmd_arg0[7:0];                              // [R18]
        min_q <= i_cmd_arg1[7:0];
        sec_q <= i_cmd_arg2[7:0];
        div_q <= 24'h00_0000;
      end else begin
        div_q <= sec_tick ? 24'h00_0000 : div_q + 24'h00_0001;
        if (sec_tick) begin
          sec_q <= (sec_q == `SCS_SEC_MAX) ? 8'h00 : sec_q + 8'h01;
          if (sec_q == `SCS_SEC_MAX) begin
            min_q <= (min_q == `SCS_SEC_MAX) ? 8'h00 : min_q + 8'h01;
            if (min_q == `SCS_SEC_MAX) begin
              hour_q <= (hour_q == `SCS_HOUR_MAX) ? 8'h00 : hour_q + 8'h01;
            end
          end
        end
      end
    end
  end

  scs_err_queue #(
    .W(16),
    .DEPTH(ERRQ_DEPTH)
  ) u_errq (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_push(err_push),
    .i_push_code(err_code),
    .i_pop(d_errq),
    .i_clear(d_cls),                                            // [R1]
    .o_head(err_head),
    .o_empty(err_empty)
  );

  assign o_resp_valid = resp_valid_q;
  assign o_resp_kind = resp_kind_q;
  assign o_resp_data = resp_data_q;
  assign o_selftest_start = tst_start_q;
  assign o_inst_reset = rst_q;
  assign o_beep = beep_q;
  assign o_beeper_en = beep_en_q;
  assign o_line_freq_60 = lfr60_q;
  assign o_path_root = root_q;
  assign o_status_byte = stb_q;

  property p_cls_clear;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    d_cls && esr_set == 8'h00 && !err_push |=> esr_q == 8'h00 && err_empty;
  endproperty
  a_cls_clear: assert property (p_cls_clear) else $error("clear left status set"); // [R1]

  property p_ese_load;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    d_ese |=> ese_q == $past(i_cmd_arg0[7:0]) ##1 (ese_q == $past(ese_q) || $past(d_ese));
  endproperty
  a_ese_load: assert property (p_ese_load) else $error("event enable not loaded"); // [R2]

  property p_esr_read;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    d_esrq |=> o_resp_valid && o_resp_data[7:0] == $past(esr_q) && esr_q == $past(esr_set);
  endproperty
  a_esr_read: assert property (p_esr_read) else $error("event read wrong"); // [R3]

  property p_sre_load;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    d_sre |=> sre_q == $past(i_cmd_arg0[7:0]);
  endproperty
  a_sre_load: assert property (p_sre_load) else $error("request enable not loaded"); // [R4]

  property p_stb_read;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    take && op_hit(i_cmd_op, `SCS_OP_STBQ) |=> o_resp_data[7:0] == o_status_byte;
  endproperty
  a_stb_read: assert property (p_stb_read) else $error("status byte reply wrong"); // [R5]

  property p_opc_hold;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    i_meas_active && !esr_q[`SCS_ESR_OPC] |=> !esr_q[`SCS_ESR_OPC];
  endproperty
  a_opc_hold: assert property (p_opc_hold) else $error("completion set while busy"); // [R7]

  property p_opcq_one;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    d_opcq ##1 (!i_meas_active && idle_st && slot_free) |=> o_resp_data == `SCS_ASCII_ONE;
  endproperty
  a_opcq_one: assert property (p_opcq_one) else $error("no completion reply"); // [R8]

  property p_defer;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    i_meas_active && !busy_ok |-> !o_cmd_ready;
  endproperty
  a_defer: assert property (p_defer) else $error("command run while measuring"); // [R9]

  property p_rst_drop;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    d_rst |=> !opc_pend_q && !opcq_pend_q && o_inst_reset && o_beeper_en;
  endproperty
  a_rst_drop: assert property (p_rst_drop) else $error("reset kept pending work"); // [R11]

  property p_lfr_bad;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    d_lfr && !lfr_ok |=> o_line_freq_60 == $past(o_line_freq_60) && esr_q[`SCS_ESR_EXE];
  endproperty
  a_lfr_bad: assert property (p_lfr_bad) else $error("bad line frequency taken"); // [R21]

  c_opc_deferred: cover property (@(posedge i_clk_sys) d_opc && i_meas_active ##[1:20] flush_opc);
  c_idn: cover property (@(posedge i_clk_sys) d_idnq ##[4:20] idle_st);
  c_test: cover property (@(posedge i_clk_sys) d_tstq ##[1:50] st_d == scs_pkg::ST_IDLE);
endmodule

// [scs_defines.svh]
/*
 Constants for the common and system command interpreter: opcodes, reply
 kinds, status bit positions, error codes, reset values and timing counts.
 Assumes it is included by bare name from the interpreter and the testbench.
 */
// What this block does
// R1: Clear-status empties every event register and the error queue.
// R2: Event-enable write loads the standard event enable; its query returns it.
// R3: Event-status query returns the standard event register and clears it.
// R4: Service-request-enable write loads that register; its query returns it.
// R5: Status-byte query returns the present status byte.
// R6: Identity query returns maker, model, serial and three-level firmware revision.
// R7: Operation-complete sets its event bit only after pending operations finish.
// R8: Operation-complete query queues ASCII 1 only after pending operations finish.
// R9: While measurement trigger layers run, most commands are held back.
// R10: On return to idle, an owed completion reply goes out before deferred commands run; the event bit is set in the first idle cycle.
// R11: Reset restores defaults, drops pending commands and owed completion replies.
// R12: Self-test query runs the test and queues its code, zero meaning pass.
// R13: Wait command is accepted without error and does nothing.
// R14: Beep sounds at once when the beeper is enabled; beeper state is settable and readable.
// R15: Error query returns the next queued error code with its message.
// R16: Version query reports SCPI level 1999.0.
// R17: Date command sets year, month, day; its query returns them.
// R18: Time command sets hour, minute, second; its query returns running time.
// R19: Line frequency selects 50 or 60 Hz; its query reports it.
// R20: A terminated command string returns the command path to root.
// R21: Other line frequency values are refused, logged, setting kept.
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH

`define SCS_OP_CLS 5'h00
`define SCS_OP_ESE 5'h01
`define SCS_OP_ESEQ 5'h02
`define SCS_OP_ESRQ 5'h03
`define SCS_OP_IDNQ 5'h04
`define SCS_OP_OPC 5'h05
`define SCS_OP_OPCQ 5'h06
`define SCS_OP_RST 5'h07
`define SCS_OP_SRE 5'h08
`define SCS_OP_SREQ 5'h09
`define SCS_OP_STBQ 5'h0A
`define SCS_OP_TSTQ 5'h0B
`define SCS_OP_WAI 5'h0C
`define SCS_OP_BEEP 5'h0D
`define SCS_OP_BEEPST 5'h0E
`define SCS_OP_BEEPSTQ 5'h0F
`define SCS_OP_ERRQ 5'h10
`define SCS_OP_VERSQ 5'h11
`define SCS_OP_DATE 5'h12
`define SCS_OP_DATEQ 5'h13
`define SCS_OP_TIME 5'h14
`define SCS_OP_TIMEQ 5'h15
`define SCS_OP_LFR 5'h16
`define SCS_OP_LFRQ 5'h17

`define SCS_RK_NUM 4'h0
`define SCS_RK_BOOL 4'h1
`define SCS_RK_CHAR 4'h2
`define SCS_RK_IDN0 4'h3
`define SCS_RK_ERR 4'h7
`define SCS_RK_VERS 4'h8
`define SCS_RK_DATE 4'h9
`define SCS_RK_TIME 4'hA

`define SCS_ESR_OPC 0
`define SCS_ESR_EXE 4
`define SCS_ESR_CME 5
`define SCS_STB_EAV 2
`define SCS_STB_MAV 4
`define SCS_STB_ESB 5
`define SCS_STB_MSS 6

`define SCS_ERR_RANGE 16'hFF22
`define SCS_ERR_HEADER 16'hFF8F
`define SCS_ASCII_ONE 32'h0000_0031
`define SCS_VERSION 32'h07CF_0000
`define SCS_LFR_50 16'h0032
`define SCS_LFR_60 16'h003C
`define SCS_SEC_MAX 8'h3B
`define SCS_HOUR_MAX 8'h17
`define SCS_MONTH_MAX 8'h0C
`define SCS_DAY_MAX 8'h1F
`define SCS_BEEP_EN_RST 1'b1
`define SCS_LFR60_RST 1'b0

`define SCS_CLK_NS 100
`define SCS_SEC_NS 1000000000
`define SCS_SEC_CYCLES (`SCS_SEC_NS / `SCS_CLK_NS)

`endif

// [scs_pkg.sv]
/*
 Types shared by the command interpreter.
 Assumes nothing of its surroundings.
 */
package scs_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_TEST = 3'b010,
    ST_IDN = 3'b100
  } scs_state_t;
endpackage

// [scs_err_queue.sv]
/*
 Error queue: a small FIFO of signed error codes with a clear input.
 Assumes DEPTH is a power of two so pointers wrap by themselves.
 */
`timescale 1ns/10ps
module scs_err_queue #(
  parameter int W = 16,
  parameter int DEPTH = 8
) (
  input wire logic i_clk_sys,           // System clock
  input wire logic i_reset_n,           // Async reset, active low
  input wire logic i_push,              // Add an error code
  input wire logic [W-1:0] i_push_code, // Code to add
  input wire logic i_pop,               // Drop the head entry
  input wire logic i_clear,             // Empty the queue
  output logic [W-1:0] o_head,          // Head entry
  output logic o_empty                  // Queue holds nothing
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] rd_q;
  logic [AW-1:0] wr_q;
  logic [AW:0] cnt_q;
  wire logic full = cnt_q == (AW+1)'(DEPTH);
  // When full, newer errors are lost and the older ones kept
  wire logic push_ok = i_push & (i_clear | ~full);
  wire logic pop_ok = i_pop & ~o_empty & ~i_clear;
  wire logic [AW-1:0] wr_at = i_clear ? '0 : wr_q;

  assign o_empty = cnt_q == '0;
  assign o_head = mem[rd_q];

  always_ff @(posedge i_clk_sys) begin
    if (push_ok) begin
      mem[wr_at] <= i_push_code;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_q <= '0;
      wr_q <= '0;
      cnt_q <= '0;
    end else if (i_clear) begin
      // An error raised in the clearing cycle survives the clear
      rd_q <= '0;
      wr_q <= AW'(push_ok);
      cnt_q <= (AW+1)'(push_ok);
    end else begin
      rd_q <= rd_q + AW'(pop_ok);
      wr_q <= wr_q + AW'(push_ok);
      cnt_q <= cnt_q + (AW+1)'(push_ok) - (AW+1)'(pop_ok);
    end
  end
endmodule

// [scs_selftest_model.sv]
/*
 Self-test engine model: answers each start pulse with a done pulse and code.
 Assumes start is a one-cycle pulse on the system clock.
 */
`timescale 1ns/10ps
module scs_selftest_model #(
  parameter int DELAY = 4,
  parameter logic [7:0] CODE = 8'h00
) (
  input wire logic i_clk_sys, // System clock
  input wire logic i_reset_n, // Async reset, active low
  input wire logic i_start,   // Start pulse
  output logic o_done,        // Done pulse
  output logic [7:0] o_code   // Result, valid with done
);
  int cnt;
  // Code toggles outside done so a stale value is never mistaken for a result
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt <= 0;
      o_done <= 1'b0;
      o_code <= 8'h55;
    end else begin
      cnt <= i_start ? DELAY : (cnt > 0 ? cnt - 1 : 0);
      o_done <= (cnt == 1);
      o_code <= (cnt == 1) ? CODE : ~o_code;
    end
  end
endmodule

// [tb_top.sv]
/*
 Testbench for the command interpreter, one task per scenario.
 Assumes the self-test model stands on the self-test port.
 */
`timescale 1ns/10ps
`include "scs_defines.svh"
module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, cv = 1'b0, rr = 1'b0, cend = 1'b1, meas = 1'b0;
  logic [4:0] op = 5'h00;
  logic [15:0] a0 = 16'h0000, a1 = 16'h0000, a2 = 16'h0000;
  logic crdy, rv, st_go, st_done, irst, beep, ben, lf60, root;
  logic [3:0] kind;
  logic [31:0] data;
  logic [7:0] stb, st_code;
  int failures = 0, comparisons = 0;
  always #50 clk = ~clk;
  scs_cmd_interp #(.SEC_CYCLES(10)) uut (.i_clk_sys(clk), .i_reset_n(rst_n),
    .i_cmd_valid(cv), .o_cmd_ready(crdy), .i_cmd_op(op), .i_cmd_arg0(a0),
    .i_cmd_arg1(a1), .i_cmd_arg2(a2), .i_cmd_end(cend),
    .o_resp_valid(rv), .i_resp_ready(rr), .o_resp_kind(kind), .o_resp_data(data),
    .i_meas_active(meas), .o_selftest_start(st_go), .i_selftest_done(st_done),
    .i_selftest_code(st_code), .o_inst_reset(irst), .o_beep(beep), .o_beeper_en(ben),
    .o_line_freq_60(lf60), .o_path_root(root), .o_status_byte(stb));
  scs_selftest_model #(.CODE(8'h5A)) st (.i_clk_sys(clk), .i_reset_n(rst_n), .i_start(st_go),
    .o_done(st_done), .o_code(st_code));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [4:0] o, input logic [15:0] x = 16'h0000,
      input logic e = 1'b1, input logic [15:0] y = 16'h0000,
      input logic [15:0] z = 16'h0000);
    int n;
    n = 0;
    @(negedge clk);
    op = o;
    a0 = x;
    a1 = y;
    a2 = z;
    cend = e;
    cv = 1'b1;
    while (crdy !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    // A command never taken counts as a mismatch
    if (crdy !== 1'b1) failures++;
    @(negedge clk);
    cv = 1'b0;
  endtask
  task automatic get(input logic [3:0] k, input logic [31:0] d);
    int n;
    n = 0;
    while (rv !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (rv !== 1'b1) failures++;
    chk({28'h0, kind}, {28'h0, k});
    chk(data, d);
    rr = 1'b1;
    @(negedge clk);
    rr = 1'b0;
  endtask
  task automatic t_regs;
    cmd(`SCS_OP_ESE, 16'h00A5);
    cmd(`SCS_OP_ESEQ);
    get(`SCS_RK_NUM, 32'h0000_00A5);
    cmd(`SCS_OP_SRE, 16'h003C);
    cmd(`SCS_OP_SREQ);
    get(`SCS_RK_NUM, 32'h0000_003C);
    cmd(`SCS_OP_WAI, 16'h0000, 1'b0);
    chk({31'h0, root}, 32'h0);
    chk({24'h0, stb}, 32'h0);
    $display("regs done");
  endtask
  task automatic t_lfr;
    cmd(`SCS_OP_LFR, 16'h003C);
    chk({31'h0, lf60}, 32'h1);
    cmd(`SCS_OP_LFR, 16'h0037);
    chk({31'h0, lf60}, 32'h1);
    cmd(`SCS_OP_ERRQ);
    get(`SCS_RK_ERR, 32'h0000_FF22);
    cmd(`SCS_OP_ESRQ);
    get(`SCS_RK_NUM, 32'h0000_0010);
    cmd(`SCS_OP_ESRQ);
    get(`SCS_RK_NUM, 32'h0);
    cmd(`SCS_OP_LFR, 16'h0007);
    cmd(`SCS_OP_CLS);
    cmd(`SCS_OP_ERRQ);
    get(`SCS_RK_ERR, 32'h0);
    $display("lfr done");
  endtask
  task automatic t_opc;
    meas = 1'b1;
    cmd(`SCS_OP_OPCQ);
    repeat (5) @(negedge clk);
    chk({31'h0, rv}, 32'h0);
    meas = 1'b0;
    get(`SCS_RK_CHAR, `SCS_ASCII_ONE);
    meas = 1'b1;
    cmd(`SCS_OP_OPCQ);
    cmd(`SCS_OP_RST);
    chk({30'h0, irst, lf60}, 32'h2);
    meas = 1'b0;
    repeat (5) @(negedge clk);
    chk({31'h0, rv}, 32'h0);
    $display("opc done");
  endtask
  task automatic t_misc;
    cmd(`SCS_OP_TSTQ);
    get(`SCS_RK_NUM, 32'h0000_005A);
    cmd(`SCS_OP_VERSQ);
    get(`SCS_RK_VERS, `SCS_VERSION);
    cmd(`SCS_OP_IDNQ);
    get(`SCS_RK_IDN0, 32'h0000_00A1);
    get(4'h4, 32'h0000_00B2);
    get(4'h5, 32'h0000_0001);
    get(4'h6, 32'h0001_0000);
    cmd(`SCS_OP_BEEPST, 16'h0000);
    chk({31'h0, ben}, 32'h0);
    cmd(`SCS_OP_BEEPST, 16'h0001);
    cmd(`SCS_OP_BEEP);
    chk({31'h0, beep}, 32'h1);
    $display("misc done");
  endtask
  task automatic t_sys;
    cmd(5'h1F);
    chk({31'h0, root}, 32'h1);
    cmd(`SCS_OP_STBQ);
    get(`SCS_RK_NUM, 32'h0000_0064);
    cmd(`SCS_OP_ERRQ);
    get(`SCS_RK_ERR, 32'h0000_FF8F);
    cmd(`SCS_OP_ESRQ);
    get(`SCS_RK_NUM, 32'h0000_0020);
    cmd(`SCS_OP_DATE, 16'h07E8, 1'b1, 16'h0003, 16'h000F);
    cmd(`SCS_OP_DATEQ);
    get(`SCS_RK_DATE, 32'h07E8_030F);
    cmd(`SCS_OP_TIME, 16'h000A, 1'b1, 16'h0022, 16'h0030);
    cmd(`SCS_OP_TIMEQ);
    get(`SCS_RK_TIME, 32'h000A_2230);
    cmd(`SCS_OP_LFRQ);
    get(`SCS_RK_NUM, 32'h0000_0032);
    cmd(`SCS_OP_BEEPSTQ);
    get(`SCS_RK_BOOL, 32'h1);
    meas = 1'b1;
    cmd(`SCS_OP_OPC);
    repeat (3) @(negedge clk);
    // An early completion bit would show as event summary in the status byte
    chk({24'h0, stb}, 32'h0);
    meas = 1'b0;
    cmd(`SCS_OP_ESRQ);
    get(`SCS_RK_NUM, 32'h1);
    cmd(`SCS_OP_OPCQ);
    get(`SCS_RK_CHAR, `SCS_ASCII_ONE);
    $display("sys done");
  endtask
  task automatic stop_test;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    t_regs();
    t_lfr();
    t_opc();
    t_misc();
    t_sys();
    stop_test();
  end
  initial begin
    #500000;
    failures++;
    stop_test();
  end
endmodule
